//--- ulm_params.svh
// register map and field positions of the line/modem block
`ifndef ULM_PARAMS_SVH
`define ULM_PARAMS_SVH
`define ULM_IDX_DATA        32'h0c000010
`define ULM_IDX_IER         32'h0c000011
`define ULM_IDX_FCR         32'h0c000012
`define ULM_IDX_LFC         32'h0c000013
`define ULM_IDX_MLC         32'h0c000014
`define ULM_IDX_MSR         32'h0c000016
`define ULM_IDX_IRQ_STAT    32'h0c000018
`define ULM_IDX_IRQ_EN      32'h0c000019
`define ULM_IDX_IRQ_CLR     32'h0c00001a
`define ULM_BYTE_ADDR(idx)  ((idx) << 2)
`define ULM_LFC_DLAB        7
`define ULM_LFC_BREAK       6
`define ULM_LFC_STICKY      5
`define ULM_LFC_EVEN        4
`define ULM_LFC_PAR_EN      3
`define ULM_LFC_STOP        2
`define ULM_LFC_LEN_HI      1
`define ULM_LFC_LEN_LO      0
`define ULM_LFC_RESET       8'h00
`define ULM_MLC_LOOP        4
`define ULM_MLC_AUX2        3
`define ULM_MLC_AUX1        2
`define ULM_MLC_RTS         1
`define ULM_MLC_DTR         0
`define ULM_MLC_WIDTH       5
`define ULM_MLC_RESET       5'h00
`define ULM_FCR_TRIG_HI     7
`define ULM_FCR_TRIG_LO     6
`define ULM_FCR_MODE        3
`define ULM_FCR_TX_CLR      2
`define ULM_FCR_RX_CLR      1
`define ULM_FCR_EN          0
`define ULM_IER_RX_DATA     0
`define ULM_IER_TX_EMPTY    1
`define ULM_IER_WIDTH       4
`define ULM_IRQ_MODEM       0
`define ULM_IRQ_TX_DONE     1
`define ULM_IRQ_RX_TRIG     2
`define ULM_IRQ_RX_TMO      3
`define ULM_IRQ_WIDTH       4
`define ULM_RESP_OKAY       2'b00
`define ULM_RESP_SLVERR     2'b10
`define ULM_MARK            1'b1
`define ULM_SPACE           1'b0
`define ULM_HALVES_BIT      3'h2
`define ULM_HALVES_STOP_1   3'h2
`define ULM_HALVES_STOP_15  3'h3
`define ULM_HALVES_STOP_2   3'h4
`define ULM_LEN_BASE        3'h4
`define ULM_LEN_MASK_SEED   8'he0

`endif

//--- ulm_pkg.sv
// types shared by the line/modem/loopback block
package ulm_pkg;

  typedef enum logic [2:0] {
    ULM_TX_IDLE   = 3'b000,
    ULM_TX_START  = 3'b001,
    ULM_TX_DATA   = 3'b010,
    ULM_TX_PARITY = 3'b011,
    ULM_TX_STOP   = 3'b100
  } ulm_tx_state_t;

endpackage : ulm_pkg

//--- ulm_tx_serializer.sv
// transmit shift path in half-bit steps
`timescale 1ns/100ps
`include "ulm_params.svh"

module ulm_tx_serializer #(
  parameter int DIV_W = 16
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             start,
  input  wire logic [7:0]       data,
  input  wire logic [1:0]       char_len,
  input  wire logic             parity_enable,
  input  wire logic             even_parity,
  input  wire logic             sticky_parity,
  input  wire logic             stop_select,
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  serial_out,
  output logic                  busy,
  output logic                  done
);

  ulm_pkg::ulm_tx_state_t state;
  logic [DIV_W-1:0]       tick_cnt;
  logic [DIV_W-1:0]       last_cnt;
  logic [2:0]             half_cnt;
  logic [2:0]             halves_need;
  logic [2:0]             bit_idx;
  logic [2:0]             last_idx;
  logic [7:0]             shreg;
  logic [7:0]             len_mask;
  logic                   parity_bit;
  logic                   half_tick;
  logic                   bit_end;

  assign last_cnt  = (divisor == '0) ? '0 : divisor - DIV_W'(1);
  assign half_tick = (tick_cnt == last_cnt);
  assign last_idx  = {1'b0, char_len} + `ULM_LEN_BASE;
  assign len_mask  = ~(`ULM_LEN_MASK_SEED << char_len);

  // R7: stop length in half bits
  always_comb begin
    if (state != ulm_pkg::ULM_TX_STOP)
      halves_need = `ULM_HALVES_BIT;
    else if (!stop_select)
      halves_need = `ULM_HALVES_STOP_1;
    else if (char_len == 2'b00)
      halves_need = `ULM_HALVES_STOP_15;
    else
      halves_need = `ULM_HALVES_STOP_2;
  end

  assign bit_end = half_tick && (half_cnt == halves_need - 3'h1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= '0;
      half_cnt <= 3'h0;
    end else if (state == ulm_pkg::ULM_TX_IDLE || bit_end) begin
      tick_cnt <= '0;
      half_cnt <= 3'h0;
    end else if (half_tick) begin
      tick_cnt <= '0;
      half_cnt <= half_cnt + 3'h1;
    end else begin
      tick_cnt <= tick_cnt + DIV_W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state      <= ulm_pkg::ULM_TX_IDLE;
      shreg      <= 8'h00;
      bit_idx    <= 3'h0;
      parity_bit <= 1'b0;
      done       <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        ulm_pkg::ULM_TX_IDLE: begin
          if (start) begin
            shreg   <= data & len_mask;
            bit_idx <= 3'h0;
            // R6: sticky sends inverse of type bit
            if (sticky_parity)
              parity_bit <= ~even_parity;
            else if (even_parity)
              parity_bit <= ^(data & len_mask);
            else
              parity_bit <= ~^(data & len_mask);
            state <= ulm_pkg::ULM_TX_START;
          end
        end
        ulm_pkg::ULM_TX_START: begin
          if (bit_end)
            state <= ulm_pkg::ULM_TX_DATA;
        end
        ulm_pkg::ULM_TX_DATA: begin
          if (bit_end) begin
            shreg   <= {1'b0, shreg[7:1]};
            bit_idx <= bit_idx + 3'h1;
            // R8: stop after the selected length
            if (bit_idx == last_idx)
              // R5: parity bit only when enabled
              state <= parity_enable ? ulm_pkg::ULM_TX_PARITY : ulm_pkg::ULM_TX_STOP;
          end
        end
        ulm_pkg::ULM_TX_PARITY: begin
          if (bit_end)
            state <= ulm_pkg::ULM_TX_STOP;
        end
        ulm_pkg::ULM_TX_STOP: begin
          if (bit_end) begin
            state <= ulm_pkg::ULM_TX_IDLE;
            done  <= 1'b1;
          end
        end
        default: state <= ulm_pkg::ULM_TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_out <= `ULM_MARK;
      busy       <= 1'b0;
    end else begin
      busy <= (state != ulm_pkg::ULM_TX_IDLE) || start;
      case (state)
        ulm_pkg::ULM_TX_START:  serial_out <= `ULM_SPACE;
        ulm_pkg::ULM_TX_DATA:   serial_out <= shreg[0];
        ulm_pkg::ULM_TX_PARITY: serial_out <= parity_bit;
        default:                serial_out <= `ULM_MARK;
      endcase
    end
  end

endmodule : ulm_tx_serializer

//--- ulm_line_modem.sv
// line format, modem control and local loopback of the serial port unit
// Summary of operation
// R1: FIFO enabled and low IER bit clear: polling
// R2: polling suppresses trigger and timeout notification
// R3: divisor access bit reroutes shared addresses
// R4: break bit forces transmit line to space
// R5: parity enable adds and checks parity
// R6: even-parity select; sticky parity with others
// R7: stop select: 1, 1.5 or 2 bits
// R8: two bits choose five to eight data bits
// R9: modem control bits 7..5 read zero
// R10: written one drives request/ready pins low
// R11: aux settings only act in loopback
// R12: loopback: tx marks, rx ignored, shift looped
// R13: loopback: modem inputs replaced, outputs high
// R14: loopback modem interrupts come from control bits
// R15: FIFO enable bit enables both FIFOs
// R16: loopback pairs ready/set-ready, rts/cts, aux1/ri, aux2/dcd
`timescale 1ns/100ps
`include "ulm_params.svh"

module ulm_line_modem #(
  parameter int DIV_W = 16
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             serial_tx_pin,
  input  wire logic        serial_rx_pin,
  input  wire logic        set_ready_input_n,
  input  wire logic        clear_to_send_input_n,
  input  wire logic        carrier_detect_input_n,
  input  wire logic        call_alert_input_n,
  output logic             terminal_ready_output_n,
  output logic             request_to_send_output_n,
  output logic             rx_line_to_receiver,
  input  wire logic [7:0]  rx_buffer_data,
  output logic             rx_buffer_read,
  input  wire logic        rx_trigger_reached,
  input  wire logic        rx_timeout,
  output logic             fifo_enable_bit,
  output logic             fifo_mode_select,
  output logic [1:0]       rx_trigger_select,
  output logic             rx_fifo_clear,
  output logic             tx_fifo_clear,
  output logic             rx_polling_mode,
  output logic             tx_polling_mode,
  output logic             parity_check_enable,
  output logic             even_parity_select,
  output logic             sticky_parity,
  output logic             stop_bit_select,
  output logic [1:0]       char_length_select,
  output logic             irq
);

  localparam logic [31:0] ADDR_DATA     = `ULM_BYTE_ADDR(`ULM_IDX_DATA);
  localparam logic [31:0] ADDR_IER      = `ULM_BYTE_ADDR(`ULM_IDX_IER);
  localparam logic [31:0] ADDR_FCR      = `ULM_BYTE_ADDR(`ULM_IDX_FCR);
  localparam logic [31:0] ADDR_LFC      = `ULM_BYTE_ADDR(`ULM_IDX_LFC);
  localparam logic [31:0] ADDR_MLC      = `ULM_BYTE_ADDR(`ULM_IDX_MLC);
  localparam logic [31:0] ADDR_MSR      = `ULM_BYTE_ADDR(`ULM_IDX_MSR);
  localparam logic [31:0] ADDR_IRQ_STAT = `ULM_BYTE_ADDR(`ULM_IDX_IRQ_STAT);
  localparam logic [31:0] ADDR_IRQ_EN   = `ULM_BYTE_ADDR(`ULM_IDX_IRQ_EN);
  localparam logic [31:0] ADDR_IRQ_CLR  = `ULM_BYTE_ADDR(`ULM_IDX_IRQ_CLR);

  logic [7:0]                    line_format_control;
  logic [`ULM_MLC_WIDTH-1:0]     modem_line_control;
  logic [`ULM_IER_WIDTH-1:0]     interrupt_enable_reg;
  logic [DIV_W-1:0]              divisor_latch;
  logic [`ULM_IRQ_WIDTH-1:0]     irq_status;
  logic [`ULM_IRQ_WIDTH-1:0]     irq_enable;
  logic [`ULM_IRQ_WIDTH-1:0]     next_irq_status;
  logic [`ULM_IRQ_WIDTH-1:0]     irq_set;
  logic [`ULM_IRQ_WIDTH-1:0]     irq_clear;

  logic        aw_have;
  logic        w_have;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic        wr_byte;
  logic        rd_fire;
  logic        dlab;
  logic        loopback;
  logic [31:0] rd_value;
  logic        rd_mapped;

  logic        tx_start;
  logic        tx_busy;
  logic        tx_done;
  logic        tx_shift_out;
  logic [3:0]  modem_now;
  logic [3:0]  modem_prev;
  logic        modem_seen;

  assign dlab     = line_format_control[`ULM_LFC_DLAB];
  assign loopback = modem_line_control[`ULM_MLC_LOOP];
  assign wr_fire  = aw_have && w_have && !bvalid;
  assign wr_byte  = wr_fire && w_strb[0];
  assign rd_fire  = arvalid && arready;

  // write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      awready <= 1'b0;
      aw_addr <= 32'h0;
    end else begin
      if (awvalid && awready) begin
        aw_have <= 1'b1;
        awready <= 1'b0;
        aw_addr <= awaddr;
      end else if (!aw_have && !bvalid) begin
        awready <= 1'b1;
      end
      if (wr_fire)
        aw_have <= 1'b0;
    end
  end

  // write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have <= 1'b0;
      wready <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else begin
      if (wvalid && wready) begin
        w_have <= 1'b1;
        wready <= 1'b0;
        w_data <= wdata;
        w_strb <= wstrb;
      end else if (!w_have && !bvalid) begin
        wready <= 1'b1;
      end
      if (wr_fire)
        w_have <= 1'b0;
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= `ULM_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      case (aw_addr)
        ADDR_DATA, ADDR_IER, ADDR_FCR, ADDR_LFC, ADDR_MLC,
        ADDR_IRQ_EN, ADDR_IRQ_CLR: bresp <= `ULM_RESP_OKAY;
        default:                   bresp <= `ULM_RESP_SLVERR;
      endcase
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // register writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_format_control  <= `ULM_LFC_RESET;
      modem_line_control   <= `ULM_MLC_RESET;
      interrupt_enable_reg <= '0;
      divisor_latch        <= '0;
      irq_enable           <= '0;
    end else if (wr_byte) begin
      case (aw_addr)
        // R3: shared addresses follow the divisor access bit
        ADDR_DATA: if (dlab) divisor_latch[7:0] <= w_data[7:0];
        ADDR_IER:
          if (dlab)
            divisor_latch[DIV_W-1:8] <= w_data[DIV_W-9:0];
          else
            interrupt_enable_reg <= w_data[`ULM_IER_WIDTH-1:0];
        ADDR_LFC:    line_format_control <= w_data[7:0];
        ADDR_MLC:    modem_line_control  <= w_data[`ULM_MLC_WIDTH-1:0];
        ADDR_IRQ_EN: irq_enable          <= w_data[`ULM_IRQ_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  // fifo control; clear bits only pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fifo_enable_bit   <= 1'b0;
      fifo_mode_select  <= 1'b0;
      rx_trigger_select <= 2'b00;
      rx_fifo_clear     <= 1'b0;
      tx_fifo_clear     <= 1'b0;
    end else begin
      rx_fifo_clear <= 1'b0;
      tx_fifo_clear <= 1'b0;
      if (wr_byte && aw_addr == ADDR_FCR) begin
        // R15: one bit enables both fifos
        fifo_enable_bit   <= w_data[`ULM_FCR_EN];
        fifo_mode_select  <= w_data[`ULM_FCR_MODE];
        rx_trigger_select <= w_data[`ULM_FCR_TRIG_HI:`ULM_FCR_TRIG_LO];
        rx_fifo_clear     <= w_data[`ULM_FCR_RX_CLR];
        tx_fifo_clear     <= w_data[`ULM_FCR_TX_CLR];
      end
    end
  end

  // R3: holding register write starts the shift path
  assign tx_start = wr_byte && !dlab && (aw_addr == ADDR_DATA) && !tx_busy;

  ulm_tx_serializer #(
    .DIV_W (DIV_W)
  ) u_tx (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .start         (tx_start),
    .data          (w_data[7:0]),
    .char_len      (line_format_control[`ULM_LFC_LEN_HI:`ULM_LFC_LEN_LO]),
    .parity_enable (line_format_control[`ULM_LFC_PAR_EN]),
    .even_parity   (line_format_control[`ULM_LFC_EVEN]),
    .sticky_parity (line_format_control[`ULM_LFC_STICKY]),
    .stop_select   (line_format_control[`ULM_LFC_STOP]),
    .divisor       (divisor_latch),
    .serial_out    (tx_shift_out),
    .busy          (tx_busy),
    .done          (tx_done)
  );

  // format settings handed to the receiver
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      parity_check_enable <= 1'b0;
      even_parity_select  <= 1'b0;
      sticky_parity       <= 1'b0;
      stop_bit_select     <= 1'b0;
      char_length_select  <= 2'b00;
    end else begin
      // R5: receive check follows the same enable
      parity_check_enable <= line_format_control[`ULM_LFC_PAR_EN];
      // R6: parity type passed as is; sticky combines with enable
      even_parity_select  <= line_format_control[`ULM_LFC_EVEN];
      sticky_parity       <= line_format_control[`ULM_LFC_STICKY] & line_format_control[`ULM_LFC_PAR_EN];
      stop_bit_select     <= line_format_control[`ULM_LFC_STOP];
      // R8: same length for receive
      char_length_select  <= line_format_control[`ULM_LFC_LEN_HI:`ULM_LFC_LEN_LO];
    end
  end

  // line and modem pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_tx_pin            <= `ULM_MARK;
      rx_line_to_receiver      <= `ULM_MARK;
      terminal_ready_output_n  <= 1'b1;
      request_to_send_output_n <= 1'b1;
    end else begin
      // R4: break wins over everything
      if (line_format_control[`ULM_LFC_BREAK])
        serial_tx_pin <= `ULM_SPACE;
      // R12: loopback holds the pin at mark
      else if (loopback)
        serial_tx_pin <= `ULM_MARK;
      else
        serial_tx_pin <= tx_shift_out;
      // R12: receiver fed from the shift output
      rx_line_to_receiver <= loopback ? tx_shift_out : serial_rx_pin;
      // R13: pins inactive in loopback
      // R10: written one gives a low pin
      terminal_ready_output_n  <= loopback | ~modem_line_control[`ULM_MLC_DTR];
      request_to_send_output_n <= loopback | ~modem_line_control[`ULM_MLC_RTS];
    end
  end

  // modem status view: {dcd, ri, dsr, cts}, active high
  always_comb begin
    // R13: inputs cut off in loopback
    if (loopback) begin
      // R16: customary pairing
      // R11: aux settings only reach anything here
      modem_now = {modem_line_control[`ULM_MLC_AUX2], modem_line_control[`ULM_MLC_AUX1],
                   modem_line_control[`ULM_MLC_DTR], modem_line_control[`ULM_MLC_RTS]};
    end else begin
      modem_now = {~carrier_detect_input_n, ~call_alert_input_n,
                   ~set_ready_input_n, ~clear_to_send_input_n};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      modem_prev <= 4'h0;
      modem_seen <= 1'b0;
    end else begin
      modem_prev <= modem_now;
      modem_seen <= 1'b1;
    end
  end

  // R1: polling per side when fifos on and enable bit clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_polling_mode <= 1'b0;
      tx_polling_mode <= 1'b0;
    end else begin
      rx_polling_mode <= fifo_enable_bit & ~interrupt_enable_reg[`ULM_IER_RX_DATA];
      tx_polling_mode <= fifo_enable_bit & ~interrupt_enable_reg[`ULM_IER_TX_EMPTY];
    end
  end

  // interrupt events
  always_comb begin
    irq_set = '0;
    // R14: modem changes from control bits in loopback
    irq_set[`ULM_IRQ_MODEM]   = modem_seen && (modem_now != modem_prev);
    irq_set[`ULM_IRQ_TX_DONE] = tx_done && !tx_polling_mode;
    // R2: polling drops trigger and timeout notice
    irq_set[`ULM_IRQ_RX_TRIG] = rx_trigger_reached && !rx_polling_mode;
    irq_set[`ULM_IRQ_RX_TMO]  = rx_timeout && !rx_polling_mode;
    irq_clear = (wr_byte && aw_addr == ADDR_IRQ_CLR) ? w_data[`ULM_IRQ_WIDTH-1:0] : '0;
    // set wins over a clear in the same cycle
    next_irq_status = (irq_status & ~irq_clear) | irq_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq        <= |(next_irq_status & irq_enable);
    end
  end

  // read mux
  always_comb begin
    rd_value  = 32'h0;
    rd_mapped = 1'b1;
    case (araddr)
      // R3: divisor latch or buffer/enables
      ADDR_DATA: rd_value[7:0] = dlab ? divisor_latch[7:0] : rx_buffer_data;
      ADDR_IER:
        if (dlab)
          rd_value[DIV_W-9:0] = divisor_latch[DIV_W-1:8];
        else
          rd_value[`ULM_IER_WIDTH-1:0] = interrupt_enable_reg;
      ADDR_FCR:      rd_value = 32'h0;
      ADDR_LFC:      rd_value[7:0] = line_format_control;
      // R9: upper bits stay zero
      ADDR_MLC:      rd_value[`ULM_MLC_WIDTH-1:0] = modem_line_control;
      ADDR_MSR:      rd_value[3:0] = modem_now;
      ADDR_IRQ_STAT: rd_value[`ULM_IRQ_WIDTH-1:0] = irq_status;
      ADDR_IRQ_EN:   rd_value[`ULM_IRQ_WIDTH-1:0] = irq_enable;
      ADDR_IRQ_CLR:  rd_value = 32'h0;
      default:       rd_mapped = 1'b0;
    endcase
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready        <= 1'b0;
      rvalid         <= 1'b0;
      rdata          <= 32'h0;
      rresp          <= `ULM_RESP_OKAY;
      rx_buffer_read <= 1'b0;
    end else begin
      rx_buffer_read <= 1'b0;
      if (rd_fire) begin
        arready        <= 1'b0;
        rvalid         <= 1'b1;
        rdata          <= rd_value;
        rresp          <= rd_mapped ? `ULM_RESP_OKAY : `ULM_RESP_SLVERR;
        rx_buffer_read <= (araddr == ADDR_DATA) && !dlab;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end else if (!rvalid) begin
        arready <= 1'b1;
      end
    end
  end

endmodule : ulm_line_modem

//--- ulm_monitor.sv
// port-level checks of the line/modem block
`timescale 1ns/100ps

module ulm_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic rx_buffer_read,
  input wire logic serial_tx_pin,
  input wire logic terminal_ready_output_n,
  input wire logic request_to_send_output_n,
  input wire logic irq,
  input wire logic sticky_parity,
  input wire logic parity_check_enable,
  input wire logic rx_polling_mode,
  input wire logic tx_polling_mode,
  input wire logic fifo_enable_bit
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence wr_wait;
    (!awready && !wready && !bvalid) ##1 (bvalid && !awready);
  endsequence

  a_write_answer: assert property (wr_taken |=> wr_wait) else $error("write answer");
  a_bresp_once: assert property (bvalid && bready |=> !bvalid) else $error("bvalid held");
  a_read_answer: assert property (arvalid && arready |=> rvalid && !arready) else $error("read answer");
  a_rdata_once: assert property (rvalid && rready |=> !rvalid) else $error("rvalid held");
  a_buf_read_pulse: assert property (rx_buffer_read |-> rvalid ##1 !rx_buffer_read) else $error("buffer read");
  a_sticky_parity: assert property (sticky_parity |-> parity_check_enable) else $error("sticky alone");
  a_poll_fifo: assert property ((rx_polling_mode || tx_polling_mode) |-> $past(fifo_enable_bit)) else $error("poll");
  a_reset_idle: assert property (disable iff (1'b0) !aresetn |=> serial_tx_pin && terminal_ready_output_n
    && request_to_send_output_n && !irq && !bvalid) else $error("reset state");
endmodule : ulm_monitor

bind ulm_line_modem ulm_monitor u_ulm_monitor (.*);

//--- ulm_modem_model.sv
// modem partner: answers handshake, drives receive line
`timescale 1ns/100ps

module ulm_modem_model (
  input  wire logic terminal_ready_output_n,
  input  wire logic request_to_send_output_n,
  input  wire logic space_req,
  input  wire logic ring_req,
  output logic      serial_rx_pin,
  output logic      set_ready_input_n,
  output logic      clear_to_send_input_n,
  output logic      carrier_detect_input_n,
  output logic      call_alert_input_n
);
  assign set_ready_input_n      = terminal_ready_output_n;
  assign clear_to_send_input_n  = request_to_send_output_n;
  assign carrier_detect_input_n = 1'b1;
  assign call_alert_input_n     = ~ring_req;
  assign serial_rx_pin          = ~space_req;
endmodule : ulm_modem_model

//--- ulm_tb.sv
// testbench of the line/modem/loopback block
`timescale 1ns/100ps
`include "ulm_params.svh"

module testbench;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        rx_trigger_reached = 0, rx_timeout = 0, space_req = 0, ring_req = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, rd_d;
  logic [7:0]  rx_buffer_data = 8'ha5;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  bresp, rresp, rx_trigger_select, char_length_select, rd_r, wr_r;
  logic        awready, wready, bvalid, arready, rvalid, serial_tx_pin, serial_rx_pin, irq;
  logic        set_ready_input_n, clear_to_send_input_n, carrier_detect_input_n, call_alert_input_n;
  logic        terminal_ready_output_n, request_to_send_output_n, rx_line_to_receiver, rx_buffer_read;
  logic        fifo_enable_bit, fifo_mode_select, rx_fifo_clear, tx_fifo_clear, rx_polling_mode;
  logic        tx_polling_mode, parity_check_enable, even_parity_select, sticky_parity, stop_bit_select;
  int          failures = 0, total_checks = 0;

  always #25 aclk = ~aclk;
  ulm_line_modem u_ulm_line_modem (.*);
  ulm_modem_model u_ulm_modem_model (.*);

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  task automatic wr(input logic [31:0] i, input logic [7:0] d);
    awaddr <= i << 2;
    wdata  <= {24'h0, d};
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) {wr_r, bready} <= {bresp, 1'b0};
    end while (bready);
  endtask : wr

  task automatic rd(input logic [31:0] i);
    araddr <= i << 2;
    {arvalid, rready} <= 2'b11;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) {rd_d, rd_r, rready} <= {rdata, rresp, 1'b0};
    end while (rready);
  endtask : rd

  task automatic chk(input logic [31:0] g, e, input string m);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk

  task automatic rchk(input logic [31:0] i, e, input string m);
    rd(i);
    chk(rd_d, e, m);
  endtask : rchk

  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict

  task automatic t_format();
    for (int k = 0; k < 4; k++) begin
      wr(`ULM_IDX_LFC, 8'h3c | k[7:0]);
      chk({char_length_select, stop_bit_select, parity_check_enable, even_parity_select, sticky_parity},
          {k[1:0], 4'hf}, "format");
    end
    wr(`ULM_IDX_LFC, 8'h23);
    chk({char_length_select, stop_bit_select, parity_check_enable, sticky_parity}, 5'h18, "no par");
    wr(`ULM_IDX_LFC, 8'h48);
    cyc(1);
    chk({serial_tx_pin, parity_check_enable, even_parity_select}, 3'h2, "odd, break");
    wr(`ULM_IDX_LFC, 8'h00);
    cyc(1);
    chk(serial_tx_pin, `ULM_MARK, "break off");
    $display("t_format done");
  endtask : t_format

  task automatic t_modem();
    ring_req <= 1'b1;
    wr(`ULM_IDX_MLC, 8'he3);
    rchk(`ULM_IDX_MLC, 8'h03, "mlc reserved");
    chk({terminal_ready_output_n, request_to_send_output_n}, 2'b00, "modem low");
    rchk(`ULM_IDX_MSR, 8'h07, "msr pins");
    wr(`ULM_IDX_MLC, 8'h00);
    cyc(1);
    chk({terminal_ready_output_n, request_to_send_output_n}, 2'b11, "modem high");
    $display("t_modem done");
  endtask : t_modem

  task automatic t_loop();
    space_req <= 1'b1;
    cyc(3);
    chk(rx_line_to_receiver, 1'b0, "rx pin");
    wr(`ULM_IDX_MLC, 8'h1f);
    cyc(1);
    chk({serial_tx_pin, terminal_ready_output_n, request_to_send_output_n, rx_line_to_receiver}, 4'hf,
        "loop idle");
    rchk(`ULM_IDX_MSR, 8'h0f, "msr aux");
    wr(`ULM_IDX_MLC, 8'h16);
    rchk(`ULM_IDX_MSR, 8'h05, "msr pairs");
    wr(`ULM_IDX_IRQ_EN, 8'h01);
    wr(`ULM_IDX_IRQ_CLR, 8'h0f);
    rchk(`ULM_IDX_IRQ_STAT, 8'h00, "stat clear");
    wr(`ULM_IDX_MLC, 8'h17);
    cyc(1);
    chk(irq, 1'b1, "modem irq");
    rchk(`ULM_IDX_IRQ_STAT, 8'h01, "modem stat");
    wr(`ULM_IDX_IRQ_EN, 8'h00);
    cyc(1);
    chk(irq, 1'b0, "masked");
    wr(`ULM_IDX_IRQ_CLR, 8'h01);
    wr(`ULM_IDX_DATA, 8'h00);
    for (int n = 0; n < 40 && rx_line_to_receiver !== 1'b0; n++) @(posedge aclk);
    chk({rx_line_to_receiver, serial_tx_pin}, 2'b01, "looped start");
    cyc(40);
    rchk(`ULM_IDX_IRQ_STAT, 8'h02, "tx done");
    {space_req, ring_req} <= 2'b00;
    wr(`ULM_IDX_MLC, 8'h00);
    $display("t_loop done");
  endtask : t_loop

  task automatic t_poll();
    for (int k = 0; k < 2; k++) begin
      wr(`ULM_IDX_IRQ_CLR, 8'h0f);
      wr(`ULM_IDX_IER, k ? 8'h0f : 8'h00);
      wr(`ULM_IDX_FCR, 8'h01);
      chk({fifo_enable_bit, rx_polling_mode, tx_polling_mode}, k ? 3'h4 : 3'h7, "poll mode");
      {rx_trigger_reached, rx_timeout} <= 2'b11;
      @(posedge aclk);
      {rx_trigger_reached, rx_timeout} <= 2'b00;
      rchk(`ULM_IDX_IRQ_STAT, k ? 8'h0c : 8'h00, "rx events");
    end
    wr(`ULM_IDX_FCR, 8'h00);
    chk(fifo_enable_bit, 1'b0, "fifo off");
    $display("t_poll done");
  endtask : t_poll

  task automatic t_dlab();
    wr(`ULM_IDX_LFC, 8'h80);
    wr(`ULM_IDX_DATA, 8'h05);
    rchk(`ULM_IDX_DATA, 8'h05, "divisor");
    wr(`ULM_IDX_LFC, 8'h00);
    rchk(`ULM_IDX_DATA, 8'ha5, "rx buffer");
    wr(32'h0c000020, 8'h01);
    chk(wr_r, `ULM_RESP_SLVERR, "wr unmapped");
    rchk(32'h0c000020, 0, "rd unmapped");
    chk(rd_r, `ULM_RESP_SLVERR, "rd resp");
    $display("t_dlab done");
  endtask : t_dlab

  initial begin
    cyc(2);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(`ULM_IDX_LFC, 0, "lfc reset");
    rchk(`ULM_IDX_MLC, 0, "mlc reset");
    t_format();
    t_modem();
    t_loop();
    t_poll();
    t_dlab();
    give_verdict();
  end

  initial begin
    cyc(4000);
    failures++;
    give_verdict();
  end
endmodule : testbench
